// ==== hw/msd_pkg.sv ====
`default_nettype none

package msd_pkg;

	// ==========================================================
	// state register geometry
	localparam int STATE_W = 5;

	// ==========================================================
	// reset and clear values
	localparam logic SYNC_RST_VAL = 1'b0;
	localparam logic FLAG_RST_VAL = 1'b0;

	// ==========================================================
	// state codes, msb is state_bit_msb, lsb is state_bit_lsb
	typedef enum logic [STATE_W-1:0] {
		node_wait         = 5'h00,
		node_a            = 5'h08,
		node_b            = 5'h0c,
		node_c            = 5'h1c,
		node_d            = 5'h14,
		node_f            = 5'h04,
		node_i            = 5'h06,
		node_n            = 5'h16,
		node_o            = 5'h0e,
		node_p            = 5'h12,
		node_q            = 5'h1e,
		node_s            = 5'h02,
		node_t            = 5'h1a,
		node_u            = 5'h0a,
		cmd_sync_lock     = 5'h03,
		node_a2           = 5'h10,
		node_b2           = 5'h11,
		node_c2           = 5'h01,
		node_d2           = 5'h09,
		node_f2           = 5'h19,
		node_i2           = 5'h1d,
		node_o2           = 5'h15,
		node_e            = 5'h0d,
		node_g            = 5'h05,
		node_h            = 5'h0f,
		node_j            = 5'h17,
		node_k            = 5'h07,
		node_l            = 5'h1f,
		payload_sync_lock = 5'h13
	} state_type;

	// unused codes, never entered
	localparam logic [STATE_W-1:0] SPARE_CODE_0 = 5'h0b;
	localparam logic [STATE_W-1:0] SPARE_CODE_1 = 5'h18;
	localparam logic [STATE_W-1:0] SPARE_CODE_2 = 5'h1b;

endpackage

`default_nettype wire

// ==== hw/bit_sync2.sv ====
`timescale 1ns/10ps
`default_nettype none

module bit_sync2 (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	// asynchronous level in
	input  wire logic i_async,
	// synchronised level out
	output var  logic o_sync
);

	// ==========================================================
	// two stage synchroniser
	logic meta_r;

	// meta_r feeds only the second stage
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= msd_pkg::SYNC_RST_VAL;
			o_sync <= msd_pkg::SYNC_RST_VAL;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule // bit_sync2

`default_nettype wire

// ==== hw/manchester_sync_detect_fsm.sv ====
// Behaviour
// - master clear forces wait state asynchronously
// - first true transition condition takes priority
// - no true condition means state holds
// - state outputs high while in that state
// - five-bit unique codes, wait is zero
// - wait goes a on one, else a2
// - a goes b on one, else wait
// - b goes c on one, else wait
// - s goes c on one, else command lock
// - command lock holds until cleared
// - f goes wait on one, else i
// - i goes o on one, else n
// - c2 goes d2 on one, else n
// - d2 goes f2 on one, else q
// - g goes k on one, else j
// - k goes wait on one, else data lock
// - u goes wait on one, else command lock
// - data lock holds until cleared
`timescale 1ns/10ps
`default_nettype none

module manchester_sync_detect_fsm (
	// clock and reset
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_rst_n,
	// master clear, asynchronous, active high
	input  wire logic                      i_master_clr,
	// manchester serial line
	input  wire logic                      i_serial_din,
	// state and lock flags
	output var  logic [msd_pkg::STATE_W-1:0] o_state,
	output var  logic                      o_cmd_sync,
	output var  logic                      o_payload_sync
);

	// ==========================================================
	// input synchronisation
	logic din_s;

	// line is asynchronous to the reference clock
	bit_sync2 u_din_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_serial_din),
		.o_sync    (din_s)
	);

	// ==========================================================
	// combined clear
	logic clr_n;

	// clear pin must be glitch free; it acts without the clock
	assign clr_n = i_rst_n & ~i_master_clr;

	// ==========================================================
	// next state
	msd_pkg::state_type state_r;
	msd_pkg::state_type state_nxt;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			msd_pkg::node_wait: begin
				if (din_s) state_nxt = msd_pkg::node_a;
				else state_nxt = msd_pkg::node_a2;
			end
			msd_pkg::node_a: begin
				if (din_s) state_nxt = msd_pkg::node_b;
				else state_nxt = msd_pkg::node_wait;
			end
			msd_pkg::node_b: begin
				if (din_s) state_nxt = msd_pkg::node_c;
				else state_nxt = msd_pkg::node_wait;
			end
			msd_pkg::node_s: begin
				if (din_s) state_nxt = msd_pkg::node_c;
				else state_nxt = msd_pkg::cmd_sync_lock;
			end
			msd_pkg::cmd_sync_lock: begin
				state_nxt = msd_pkg::cmd_sync_lock;
			end
			msd_pkg::node_f: begin
				if (din_s) state_nxt = msd_pkg::node_wait;
				else state_nxt = msd_pkg::node_i;
			end
			msd_pkg::node_i: begin
				if (din_s) state_nxt = msd_pkg::node_o;
				else state_nxt = msd_pkg::node_n;
			end
			msd_pkg::node_c2: begin
				if (din_s) state_nxt = msd_pkg::node_d2;
				else state_nxt = msd_pkg::node_n;
			end
			msd_pkg::node_d2: begin
				if (din_s) state_nxt = msd_pkg::node_f2;
				else state_nxt = msd_pkg::node_q;
			end
			msd_pkg::node_g: begin
				if (din_s) state_nxt = msd_pkg::node_k;
				else state_nxt = msd_pkg::node_j;
			end
			msd_pkg::node_k: begin
				if (din_s) state_nxt = msd_pkg::node_wait;
				else state_nxt = msd_pkg::payload_sync_lock;
			end
			msd_pkg::node_u: begin
				if (din_s) state_nxt = msd_pkg::node_wait;
				else state_nxt = msd_pkg::cmd_sync_lock;
			end
			msd_pkg::payload_sync_lock: begin
				state_nxt = msd_pkg::payload_sync_lock;
			end
			msd_pkg::node_e: begin
				if (din_s) state_nxt = msd_pkg::node_wait;
				else state_nxt = msd_pkg::node_h;
			end
			msd_pkg::node_o: begin
				if (din_s) state_nxt = msd_pkg::node_b;
				else state_nxt = msd_pkg::node_q;
			end
			msd_pkg::node_h: begin
				if (din_s) state_nxt = msd_pkg::node_k;
				else state_nxt = msd_pkg::node_l;
			end
			msd_pkg::node_a2: begin
				if (din_s) state_nxt = msd_pkg::node_wait;
				else state_nxt = msd_pkg::node_b2;
			end
			msd_pkg::node_b2: begin
				if (din_s) state_nxt = msd_pkg::node_wait;
				else state_nxt = msd_pkg::node_c2;
			end
			msd_pkg::node_p: begin
				if (din_s) state_nxt = msd_pkg::node_s;
				else state_nxt = msd_pkg::node_t;
			end
			msd_pkg::node_d: begin
				if (din_s) state_nxt = msd_pkg::node_g;
				else state_nxt = msd_pkg::node_f;
			end
			msd_pkg::node_o2: begin
				if (din_s) state_nxt = msd_pkg::node_g;
				else state_nxt = msd_pkg::node_b2;
			end
			msd_pkg::node_n: begin
				if (din_s) state_nxt = msd_pkg::node_p;
				else state_nxt = msd_pkg::node_wait;
			end
			msd_pkg::node_j: begin
				if (din_s) state_nxt = msd_pkg::payload_sync_lock;
				else state_nxt = msd_pkg::node_wait;
			end
			msd_pkg::node_f2: begin
				if (din_s) state_nxt = msd_pkg::node_i2;
				else state_nxt = msd_pkg::node_wait;
			end
			msd_pkg::node_t: begin
				if (din_s) state_nxt = msd_pkg::cmd_sync_lock;
				else state_nxt = msd_pkg::node_wait;
			end
			msd_pkg::node_c: begin
				if (din_s) state_nxt = msd_pkg::node_e;
				else state_nxt = msd_pkg::node_d;
			end
			msd_pkg::node_i2: begin
				if (din_s) state_nxt = msd_pkg::node_e;
				else state_nxt = msd_pkg::node_o2;
			end
			msd_pkg::node_q: begin
				if (din_s) state_nxt = msd_pkg::node_u;
				else state_nxt = msd_pkg::node_t;
			end
			msd_pkg::node_l: begin
				if (din_s) state_nxt = msd_pkg::payload_sync_lock;
				else state_nxt = msd_pkg::node_c2;
			end
			default: begin
				// spare codes hold, as the machine would
				state_nxt = state_r;
			end
		endcase
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_ref_clk or negedge clr_n) begin
		if (!clr_n) begin
			state_r <= msd_pkg::node_wait;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_state = state_r;

	// ==========================================================
	// lock flags, registered from next state so they track state_r
	always_ff @(posedge i_ref_clk or negedge clr_n) begin
		if (!clr_n) begin
			o_cmd_sync     <= msd_pkg::FLAG_RST_VAL;
			o_payload_sync <= msd_pkg::FLAG_RST_VAL;
		end else begin
			o_cmd_sync     <= (state_nxt == msd_pkg::cmd_sync_lock);
			o_payload_sync <= (state_nxt == msd_pkg::payload_sync_lock);
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!clr_n);

	clear_to_wait_a: assert property (
		$rose(clr_n) |-> state_r == msd_pkg::node_wait)
		else $error("state not wait after clear");

	spare_code_a: assert property (
		state_r != msd_pkg::SPARE_CODE_0 && state_r != msd_pkg::SPARE_CODE_1
		&& state_r != msd_pkg::SPARE_CODE_2)
		else $error("state took an unused code");

	wait_exit_a: assert property (
		state_r == msd_pkg::node_wait |=>
		state_r == ($past(din_s) ? msd_pkg::node_a : msd_pkg::node_a2))
		else $error("wrong exit from wait");

	a_step_a: assert property (
		state_r == msd_pkg::node_a |=>
		state_r == ($past(din_s) ? msd_pkg::node_b : msd_pkg::node_wait))
		else $error("wrong exit from node a");

	b_step_a: assert property (
		state_r == msd_pkg::node_b |=>
		state_r == ($past(din_s) ? msd_pkg::node_c : msd_pkg::node_wait))
		else $error("wrong exit from node b");

	s_step_a: assert property (
		state_r == msd_pkg::node_s && !din_s |=>
		state_r == msd_pkg::cmd_sync_lock ##1 o_cmd_sync)
		else $error("node s did not lock command");

	cmd_hold_a: assert property (
		state_r == msd_pkg::cmd_sync_lock |=> state_r == msd_pkg::cmd_sync_lock [*4])
		else $error("command lock left");

	f_step_a: assert property (
		state_r == msd_pkg::node_f |=>
		state_r == ($past(din_s) ? msd_pkg::node_wait : msd_pkg::node_i))
		else $error("wrong exit from node f");

	i_step_a: assert property (
		state_r == msd_pkg::node_i |=>
		state_r == ($past(din_s) ? msd_pkg::node_o : msd_pkg::node_n))
		else $error("wrong exit from node i");

	c2_step_a: assert property (
		state_r == msd_pkg::node_c2 |=>
		state_r == ($past(din_s) ? msd_pkg::node_d2 : msd_pkg::node_n))
		else $error("wrong exit from node c2");

	d2_step_a: assert property (
		state_r == msd_pkg::node_d2 |=>
		state_r == ($past(din_s) ? msd_pkg::node_f2 : msd_pkg::node_q))
		else $error("wrong exit from node d2");

	g_step_a: assert property (
		state_r == msd_pkg::node_g |=>
		state_r == ($past(din_s) ? msd_pkg::node_k : msd_pkg::node_j))
		else $error("wrong exit from node g");

	k_step_a: assert property (
		state_r == msd_pkg::node_k && !din_s |=> o_payload_sync && !o_cmd_sync)
		else $error("node k did not lock payload");

	u_step_a: assert property (
		state_r == msd_pkg::node_u |=>
		state_r == ($past(din_s) ? msd_pkg::node_wait : msd_pkg::cmd_sync_lock))
		else $error("wrong exit from node u");

	payload_hold_a: assert property (
		o_payload_sync |=> o_payload_sync [*3])
		else $error("payload lock left");

	flag_track_a: assert property (
		o_cmd_sync == (state_r == msd_pkg::cmd_sync_lock)
		&& o_payload_sync == (state_r == msd_pkg::payload_sync_lock))
		else $error("lock flag does not match state");

	// sync stages are zeroed by reset only, so skip two edges after it
	sample_path_a: assert property (
		state_r == msd_pkg::node_wait && $past(i_serial_din, 2)
		&& $past(i_rst_n) && $past(i_rst_n, 2) |=> state_r == msd_pkg::node_a)
		else $error("serial sample path is not two stages");

	q_step_a: assert property (
		state_r == msd_pkg::node_q |=>
		state_r == ($past(din_s) ? msd_pkg::node_u : msd_pkg::node_t))
		else $error("wrong exit from node q");

	c_step_a: assert property (
		state_r == msd_pkg::node_c |=>
		state_r == ($past(din_s) ? msd_pkg::node_e : msd_pkg::node_d))
		else $error("wrong exit from node c");

	o_step_a: assert property (
		state_r == msd_pkg::node_o |=>
		state_r == ($past(din_s) ? msd_pkg::node_b : msd_pkg::node_q))
		else $error("wrong exit from node o");

	j_step_a: assert property (
		state_r == msd_pkg::node_j |=>
		state_r == ($past(din_s) ? msd_pkg::payload_sync_lock : msd_pkg::node_wait))
		else $error("wrong exit from node j");

	l_step_a: assert property (
		state_r == msd_pkg::node_l |=>
		state_r == ($past(din_s) ? msd_pkg::payload_sync_lock : msd_pkg::node_c2))
		else $error("wrong exit from node l");

	i2_step_a: assert property (
		state_r == msd_pkg::node_i2 |=>
		state_r == ($past(din_s) ? msd_pkg::node_e : msd_pkg::node_o2))
		else $error("wrong exit from node i2");

	cmd_lock_c: cover property (
		state_r == msd_pkg::node_t && din_s ##1 o_cmd_sync);

	payload_lock_c: cover property (
		state_r == msd_pkg::node_j && din_s ##1 o_payload_sync);

	a2_path_c: cover property (
		state_r == msd_pkg::node_a2 ##1 state_r == msd_pkg::node_b2
		##1 state_r == msd_pkg::node_c2);

	fall_back_c: cover property (
		state_r == msd_pkg::node_b ##1 state_r == msd_pkg::node_wait);

	cmd_direct_c: cover property (
		state_r == msd_pkg::node_u && !din_s ##1 o_cmd_sync);

endmodule // manchester_sync_detect_fsm

`default_nettype wire

// ==== verification/serial_line_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// serial line partner, one manchester half-cell per clock
module serial_line_model (
	// clock
	input  wire logic i_ref_clk,
	// cell requested by the bench
	input  wire logic i_bit,
	// line into the detector
	output var  logic o_line
);
	initial o_line = 1'b0;

	// line is always driven, so it never floats between cells
	always @(posedge i_ref_clk) o_line <= #2 i_bit;
endmodule // serial_line_model

`default_nettype wire

// ==== verification/manchester_sync_detect_fsm_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module manchester_sync_detect_fsm_tb;
	logic        i_ref_clk    = 1'b0;
	logic        i_rst_n      = 1'b0;
	logic        i_master_clr = 1'b0;
	logic        tx_bit       = 1'b0;
	logic        i_serial_din;
	logic [4:0]  o_state;
	logic        o_cmd_sync;
	logic        o_payload_sync;
	logic [4:0]  m_st         = 5'h00;
	logic        m_s1         = 1'b0;
	logic        m_s2         = 1'b0;
	logic [4:0]  e;
	logic [4:0]  exp_q[$];
	int          failures     = 0;
	int          compares     = 0;

	always #25 i_ref_clk = ~i_ref_clk;

	serial_line_model line (.i_ref_clk(i_ref_clk), .i_bit(tx_bit), .o_line(i_serial_din));

	manchester_sync_detect_fsm dut (
		.i_ref_clk     (i_ref_clk),
		.i_rst_n       (i_rst_n),
		.i_master_clr  (i_master_clr),
		.i_serial_din  (i_serial_din),
		.o_state       (o_state),
		.o_cmd_sync    (o_cmd_sync),
		.o_payload_sync(o_payload_sync)
	);

	// ==========================================================
	// reference next state, {on one, on zero}
	function automatic logic [4:0] nxt(input logic [4:0] s, input logic d);
		logic [9:0] t;
		case (s)
			5'h00: t = {5'h08, 5'h10};  5'h08: t = {5'h0c, 5'h00};
			5'h0c: t = {5'h1c, 5'h00};  5'h1c: t = {5'h0d, 5'h14};
			5'h14: t = {5'h05, 5'h04};  5'h04: t = {5'h00, 5'h06};
			5'h06: t = {5'h0e, 5'h16};  5'h16: t = {5'h12, 5'h00};
			5'h0e: t = {5'h0c, 5'h1e};  5'h12: t = {5'h02, 5'h1a};
			5'h1e: t = {5'h0a, 5'h1a};  5'h02: t = {5'h1c, 5'h03};
			5'h1a: t = {5'h03, 5'h00};  5'h0a: t = {5'h00, 5'h03};
			5'h10: t = {5'h00, 5'h11};  5'h11: t = {5'h00, 5'h01};
			5'h01: t = {5'h09, 5'h16};  5'h09: t = {5'h19, 5'h1e};
			5'h19: t = {5'h1d, 5'h00};  5'h1d: t = {5'h0d, 5'h15};
			5'h15: t = {5'h05, 5'h11};  5'h0d: t = {5'h00, 5'h0f};
			5'h05: t = {5'h07, 5'h17};  5'h0f: t = {5'h07, 5'h1f};
			5'h17: t = {5'h13, 5'h00};  5'h07: t = {5'h00, 5'h13};
			5'h1f: t = {5'h13, 5'h01};
			default: t = {s, s};
		endcase
		return d ? t[9:5] : t[4:0];
	endfunction

	// ==========================================================
	// expectation per edge; sync stages survive the master clear
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			m_s1 = 1'b0;
			m_s2 = 1'b0;
			m_st = 5'h00;
		end else begin
			m_st = i_master_clr ? 5'h00 : nxt(m_st, m_s2);
			m_s2 = m_s1;
			m_s1 = i_serial_din;
		end
		exp_q.push_back(m_st);
	end

	// clears act at once, so they override the noted value
	always @(negedge i_ref_clk) begin
		if (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (!i_rst_n || i_master_clr)
				e = 5'h00;
			check(o_state, e);
			check({4'h0, o_cmd_sync}, {4'h0, e == 5'h03});
			check({4'h0, o_payload_sync}, {4'h0, e == 5'h13});
		end
	end

	task automatic check(input logic [4:0] seen, input logic [4:0] want);
		compares++;
		if (seen !== want) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic finish_test;
		$display("counts: compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// clear spans the sync latency, so cell 0 is the first step from wait
	task automatic run(input string p);
		for (int k = 0; k < p.len(); k++) begin
			@(posedge i_ref_clk);
			#2;
			tx_bit = (p[k] == "1");
			i_master_clr = (k < 3);
		end
	endtask

	task automatic rand_bits(input int n, input int clr_rate);
		repeat (n) begin
			@(posedge i_ref_clk);
			#2;
			tx_bit = $urandom % 2;
			i_master_clr = (clr_rate > 0) && ($urandom % clr_rate == 0);
		end
	endtask

	initial begin
		#(50 * 20000);
		failures++;
		$display("watchdog expired");
		finish_test();
	end

	initial begin
		void'($urandom(32'he54ab675));
		repeat (8) @(posedge i_ref_clk);
		#2;
		i_rst_n = 1'b1;
		$display("test reset done");
		run("1110000101");
		rand_bits(20, 0);
		check({4'h0, o_cmd_sync}, 5'h01);
		$display("test command lock done");
		@(posedge i_ref_clk);
		#2;
		i_master_clr = 1'b1;
		@(negedge i_ref_clk);
		check(o_state, 5'h00);
		$display("test async clear done");
		run("0001111010");
		rand_bits(20, 0);
		check({4'h0, o_payload_sync}, 5'h01);
		$display("test data lock done");
		rand_bits(1500, 12);
		@(posedge i_ref_clk);
		#2;
		i_rst_n = 1'b0;
		@(negedge i_ref_clk);
		check(o_state, 5'h00);
		rand_bits(3, 0);
		i_rst_n = 1'b1;
		rand_bits(1500, 12);
		$display("test random walk done");
		finish_test();
	end
endmodule // manchester_sync_detect_fsm_tb

`default_nettype wire
